// ---- inc/sar_adc_pkg.sv ----
// constants, encodings and field layout for the 8-bit converter control block
// ==========================================================================
package sar_adc_pkg;
  // ========================================================================
  // register map
  localparam logic [7:0] CFG_ADDR = 8'hBC;
  localparam logic [7:0] RESULT_ADDR = 8'hBE;
  localparam logic [7:0] CFG_RESET = 8'hF8;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int DIV_MSB = 7;
  localparam int DIV_LSB = 3;
  localparam int UNUSED_BIT = 2;
  localparam int GAIN_MSB = 1;
  localparam int GAIN_LSB = 0;
  // ========================================================================
  // gain codes
  localparam logic [1:0] GAIN_HALF = 2'h0;
  localparam logic [1:0] GAIN_ONE = 2'h1;
  localparam logic [1:0] GAIN_TWO = 2'h2;
  localparam logic [1:0] GAIN_FOUR = 2'h3;
  // ========================================================================
  // input choices: pins 0..7, then temperature and supply on the positive side,
  // ground on the negative side
  localparam logic [3:0] LAST_PIN = 4'h7;
  localparam logic [3:0] TEMP_CHOICE = 4'h8;
  localparam logic [3:0] SUPPLY_CHOICE = 4'h9;
  localparam logic [3:0] GROUND_CHOICE = 4'h8;
  // ========================================================================
  // conversion timing, in sar_clock periods
  localparam logic [3:0] CONV_CLOCKS = 4'hB;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [7:0] FIRST_TRIAL = 8'h80;
  typedef enum logic [0:0] {IDLE, CONVERT} conv_state_type;
endpackage

// ---- rtl/sar_adc_control.sv ----
// control logic of the 8-bit successive-approximation converter
`timescale 1ns/1ns
`default_nettype none
module sar_adc_control (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_write,
  input wire logic sfr_read,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // control levels and start strobe
  input wire logic converter_on,
  input wire logic start_convert,
  input wire logic diff_mode,
  input wire logic [3:0] pos_choice,
  input wire logic [3:0] neg_choice,
  input wire logic [7:0] window_low,
  input wire logic [7:0] window_high,
  // analog front end
  input wire logic comp_in,
  output logic analog_power,
  output logic track_hold,
  output logic [7:0] sar_code,
  output logic [3:0] pos_sel,
  output logic [3:0] neg_sel,
  output logic [1:0] amp_gain_select,
  output logic amp_diff,
  // status
  output logic busy,
  output logic conv_done,
  output logic window_hit
);
  // ========================================================================
  // state
  sar_adc_pkg::conv_state_type state;
  logic [7:0] configuration;
  logic [7:0] result;
  logic [4:0] div_count;
  logic [3:0] tick_count;
  logic comp_meta;
  logic comp_sync;
  logic sar_tick;
  logic start_ok;
  logic last_tick;
  logic [7:0] next_result;
  logic [4:0] divisor;

  // window test, signed when the result is two's complement
  function automatic logic in_window(input logic [7:0] v, input logic [7:0] lo,
                                     input logic [7:0] hi, input logic signed_cmp);
    if (signed_cmp) begin
      in_window = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
    end else begin
      in_window = (v >= lo) && (v <= hi);
    end
  endfunction

  assign divisor = configuration[sar_adc_pkg::DIV_MSB:sar_adc_pkg::DIV_LSB];
  assign amp_gain_select = configuration[sar_adc_pkg::GAIN_MSB:sar_adc_pkg::GAIN_LSB];
  assign busy = (state == sar_adc_pkg::CONVERT);
  assign track_hold = busy;
  // ========================================================================
  // a start is refused outside idle, in shutdown, or for a choice out of range
  assign start_ok = start_convert && converter_on && !busy
                    && (pos_choice <= sar_adc_pkg::SUPPLY_CHOICE)
                    && (diff_mode ? (neg_choice <= sar_adc_pkg::GROUND_CHOICE) : 1'b1);
  assign sar_tick = busy && (div_count == divisor);
  assign last_tick = sar_tick && (tick_count == sar_adc_pkg::CONV_CLOCKS - 4'h1);
  // offset-binary code becomes two's complement by flipping the sign bit
  assign next_result = amp_diff ? {~sar_code[7], sar_code[6:0]} : sar_code;

  // comparator is asynchronous to clk, so it is synchronised first
  always_ff @(posedge clk) begin
    if (reset) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= comp_in;
      comp_sync <= comp_meta;
    end
  end

  // power follows the enable; shutdown drops the analog side
  always_ff @(posedge clk) begin
    if (reset) begin
      analog_power <= 1'b0;
    end else begin
      analog_power <= converter_on;
    end
  end

  // configuration register; bit 2 is never stored
  always_ff @(posedge clk) begin
    if (reset) begin
      configuration <= sar_adc_pkg::CFG_RESET;
    end else if (sfr_write && sfr_addr == sar_adc_pkg::CFG_ADDR) begin
      configuration <= sfr_wdata & ~(8'h01 << sar_adc_pkg::UNUSED_BIT);
    end
  end

  // conversion sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= sar_adc_pkg::IDLE;
    end else if (!converter_on) begin
      state <= sar_adc_pkg::IDLE;
    end else begin
      case (state)
        sar_adc_pkg::IDLE: begin
          if (start_ok) begin
            state <= sar_adc_pkg::CONVERT;
          end
        end
        sar_adc_pkg::CONVERT: begin
          if (last_tick) begin
            state <= sar_adc_pkg::IDLE;
          end
        end
        default: state <= sar_adc_pkg::IDLE;
      endcase
    end
  end

  // divider: one-cycle sar_tick every divisor+1 core clocks, held clear when idle
  always_ff @(posedge clk) begin
    if (reset || !busy || sar_tick) begin
      div_count <= 5'h00;
    end else begin
      div_count <= div_count + 5'h01;
    end
  end

  // sar_clock periods elapsed in this conversion
  always_ff @(posedge clk) begin
    if (reset || !busy) begin
      tick_count <= 4'h0;
    end else if (sar_tick) begin
      tick_count <= tick_count + 4'h1;
    end
  end

  // successive approximation: first eight periods decide one bit each, MSB first
  always_ff @(posedge clk) begin
    if (reset) begin
      sar_code <= 8'h00;
    end else if (start_ok) begin
      sar_code <= sar_adc_pkg::FIRST_TRIAL;
    end else if (sar_tick && tick_count < sar_adc_pkg::DATA_BITS) begin
      sar_code[3'(4'h7 - tick_count)] <= comp_sync;
      if (tick_count != 4'h7) begin
        sar_code[3'(4'h6 - tick_count)] <= 1'b1;
      end
    end
  end

  // input selection and mode are frozen for the whole conversion
  always_ff @(posedge clk) begin
    if (reset) begin
      pos_sel <= 4'h0;
      neg_sel <= sar_adc_pkg::GROUND_CHOICE;
      amp_diff <= 1'b0;
    end else if (start_ok) begin
      pos_sel <= pos_choice;
      neg_sel <= diff_mode ? neg_choice : sar_adc_pkg::GROUND_CHOICE;
      amp_diff <= diff_mode;
    end
  end

  // result register: a finishing conversion wins over a software write
  always_ff @(posedge clk) begin
    if (reset) begin
      result <= sar_adc_pkg::RESULT_RESET;
    end else if (last_tick) begin
      result <= next_result;
    end else if (sfr_write && sfr_addr == sar_adc_pkg::RESULT_ADDR) begin
      result <= sfr_wdata;
    end
  end

  // completion and window pulses, one cycle after the last period
  always_ff @(posedge clk) begin
    if (reset) begin
      conv_done <= 1'b0;
      window_hit <= 1'b0;
    end else begin
      conv_done <= last_tick;
      window_hit <= last_tick && in_window(next_result, window_low, window_high, amp_diff);
    end
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_read) begin
      if (sfr_addr == sar_adc_pkg::CFG_ADDR) begin
        sfr_rdata <= configuration;
      end else if (sfr_addr == sar_adc_pkg::RESULT_ADDR) begin
        sfr_rdata <= result;
      end else begin
        sfr_rdata <= sar_adc_pkg::UNMAPPED_READ;
      end
    end
  end

  // ========================================================================
  // checks
  logic [4:0] gap_count;
  logic [3:0] ticks_seen;
  logic had_tick;

  // cycles between sar_ticks and ticks per conversion, for the checks only
  always_ff @(posedge clk) begin
    if (reset || !busy) begin
      gap_count <= 5'h00;
      ticks_seen <= 4'h0;
      had_tick <= 1'b0;
    end else if (sar_tick) begin
      gap_count <= 5'h00;
      ticks_seen <= ticks_seen + 4'h1;
      had_tick <= 1'b1;
    end else begin
      gap_count <= gap_count + 5'h01;
    end
  end

  sequence conv_begin_s;
    start_ok ##1 busy;
  endsequence

  sequence conv_hold_s;
    busy [*8];
  endsequence

  shutdown_idle_a: assert property (@(posedge clk) disable iff (reset)
    !converter_on |=> !busy && !analog_power) else $error("converter active in shutdown");
  start_enabled_a: assert property (@(posedge clk) disable iff (reset)
    $rose(busy) |-> $past(converter_on)) else $error("conversion began while disabled");
  conv_length_a: assert property (@(posedge clk) disable iff (reset)
    conv_begin_s |-> conv_hold_s) else $error("conversion ended too early");
  eleven_ticks_a: assert property (@(posedge clk) disable iff (reset)
    last_tick |-> ticks_seen == 4'hA ##1 conv_done && !busy) else $error("conversion length wrong");
  tick_gap_a: assert property (@(posedge clk) disable iff (reset)
    sar_tick && had_tick && $stable(divisor) |-> gap_count == divisor)
    else $error("sar clock period wrong");
  unused_zero_a: assert property (@(posedge clk) disable iff (reset)
    sfr_read && sfr_addr == sar_adc_pkg::CFG_ADDR |=> !sfr_rdata[sar_adc_pkg::UNUSED_BIT])
    else $error("unused bit reads one");
  gain_write_a: assert property (@(posedge clk) disable iff (reset)
    sfr_write && sfr_addr == sar_adc_pkg::CFG_ADDR |=> amp_gain_select == $past(sfr_wdata[1:0]))
    else $error("gain field not taken");
  result_format_a: assert property (@(posedge clk) disable iff (reset)
    conv_done |-> result == (amp_diff ? {~sar_code[7], sar_code[6:0]} : sar_code))
    else $error("result format wrong");
  window_pulse_a: assert property (@(posedge clk) disable iff (reset)
    window_hit |-> conv_done && $past(busy)) else $error("window hit outside completion");
  single_ground_a: assert property (@(posedge clk) disable iff (reset)
    busy && !amp_diff |-> neg_sel == sar_adc_pkg::GROUND_CHOICE) else $error("single-ended not grounded");
  choice_range_a: assert property (@(posedge clk) disable iff (reset)
    busy |-> pos_sel <= sar_adc_pkg::SUPPLY_CHOICE) else $error("input choice out of range");
  hold_track_a: assert property (@(posedge clk) disable iff (reset)
    conv_begin_s |-> track_hold && sar_code == sar_adc_pkg::FIRST_TRIAL)
    else $error("no hold during conversion");
endmodule
`default_nettype wire

// ---- test/analog_front_model.sv ----
// behavioural analog front end answering the converter's trial codes
`timescale 1ns/1ns
`default_nettype none
module analog_front_model (
  // clock and converter side
  input wire logic clk,
  input wire logic analog_power,
  input wire logic [7:0] sar_code,
  // level the bench wants measured, as a final code
  input wire logic [7:0] target,
  // comparator result
  output logic comp_in
);
  logic idle_toggle = 1'b0;
  // ==========================================================
  // comparator
  // unpowered output is meaningless, so it toggles instead of holding
  always @(posedge clk) begin
    idle_toggle <= ~idle_toggle;
  end
  // powered: one while the held input is at or above the trial code
  assign comp_in = analog_power ? (target >= sar_code) : idle_toggle;
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, reset, sfr_write, sfr_read, converter_on, start_convert, diff_mode, comp_in;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, window_low, window_high, sar_code, target;
  logic [3:0] pos_choice, neg_choice, pos_sel, neg_sel;
  logic [1:0] amp_gain_select;
  logic analog_power, track_hold, amp_diff, busy, conv_done, window_hit;
  logic rd_d = 1'b0;
  logic [7:0] last_r = 8'h00;
  int error_cnt = 0;
  int checks = 0;
  logic [7:0] exp_rd[$];
  logic exp_win[$];
  // ==========================================================
  // design and analog partner
  sar_adc_control dut (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_write(sfr_write),
    .sfr_read(sfr_read), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .converter_on(converter_on), .start_convert(start_convert), .diff_mode(diff_mode),
    .pos_choice(pos_choice), .neg_choice(neg_choice), .window_low(window_low),
    .window_high(window_high), .comp_in(comp_in), .analog_power(analog_power),
    .track_hold(track_hold), .sar_code(sar_code), .pos_sel(pos_sel), .neg_sel(neg_sel),
    .amp_gain_select(amp_gain_select), .amp_diff(amp_diff), .busy(busy),
    .conv_done(conv_done), .window_hit(window_hit));
  analog_front_model afe (.clk(clk), .analog_power(analog_power), .sar_code(sar_code),
    .target(target), .comp_in(comp_in));
  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_write <= 1'b1;
    @(posedge clk);
    sfr_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_read <= 1'b1;
    exp_rd.push_back(e);
    @(posedge clk);
    sfr_read <= 1'b0;
  endtask
  // start pulse; the second edge is the one that takes it
  task automatic pulse_start(input logic [3:0] p);
    @(posedge clk);
    pos_choice <= p;
    start_convert <= 1'b1;
    @(posedge clk);
    start_convert <= 1'b0;
    #1;
  endtask
  task automatic conv(input logic [4:0] d, input logic [3:0] p, input logic df);
    int n;
    logic [7:0] r, lo, hi;
    target = 8'($urandom);
    lo = 8'($urandom);
    hi = 8'($urandom);
    r = df ? (target ^ 8'h80) : target;
    wr(sar_adc_pkg::CFG_ADDR, {d, 3'h0});
    diff_mode <= df;
    window_low <= lo;
    window_high <= hi;
    exp_win.push_back(df ? ($signed(r) >= $signed(lo) && $signed(r) <= $signed(hi))
                         : (r >= lo && r <= hi));
    pulse_start(p);
    check("busy", {7'h0, busy}, 8'h01);
    check("pos_sel", {4'h0, pos_sel}, {4'h0, p});
    check("neg_sel", {4'h0, neg_sel}, df ? 8'h01 : {4'h0, sar_adc_pkg::GROUND_CHOICE});
    check("amp_diff", {7'h0, amp_diff}, {7'h0, df});
    check("track_hold", {7'h0, track_hold}, 8'h01);
    check("on power", {7'h0, analog_power}, 8'h01);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      #1;
    end while (conv_done !== 1'b1 && n < 600);
    check("cycles", n[7:0], 8'(11 * (d + 1)));
    rd(sar_adc_pkg::RESULT_ADDR, r);
    last_r = r;
  endtask
  // ==========================================================
  // result watcher: read data one cycle late, window flag with done
  always @(posedge clk) begin
    rd_d <= sfr_read;
    if (rd_d) check("sfr_rdata", sfr_rdata, exp_rd.pop_front());
    if (conv_done === 1'b1) begin
      if (exp_win.size() == 0) check("conv_done", 8'h01, 8'h00);
      else check("window_hit", {7'h0, window_hit}, {7'h0, exp_win.pop_front()});
    end
  end
  // ==========================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    {reset, sfr_write, sfr_read, start_convert, diff_mode, converter_on} = 6'h20;
    {sfr_addr, sfr_wdata, window_low, window_high, target} = '0;
    pos_choice = 4'h0;
    neg_choice = 4'h1;
    void'($urandom(54684));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(sar_adc_pkg::CFG_ADDR, sar_adc_pkg::CFG_RESET);
    rd(sar_adc_pkg::RESULT_ADDR, sar_adc_pkg::RESULT_RESET);
    rd(8'h55, sar_adc_pkg::UNMAPPED_READ);
    // bit 2 is written high and must read back low
    for (int g = 0; g < 4; g++) begin
      wr(sar_adc_pkg::CFG_ADDR, 8'h14 | 8'(g));
      rd(sar_adc_pkg::CFG_ADDR, 8'h10 | 8'(g));
      #1 check("gain", {6'h0, amp_gain_select}, 8'(g));
    end
    // shut down: no power, no start
    pulse_start(4'h0);
    check("off busy", {7'h0, busy}, 8'h00);
    check("off power", {7'h0, analog_power}, 8'h00);
    converter_on <= 1'b1;
    for (int i = 0; i < 10; i++) conv(5'h02, 4'(i), i[0]);
    conv(5'h03, 4'h9, 1'b0);
    pulse_start(4'hA);
    check("bad choice", {7'h0, busy}, 8'h00);
    // differential start against a negative choice past ground is refused
    diff_mode <= 1'b1;
    neg_choice <= 4'h9;
    pulse_start(4'h2);
    check("bad neg", {7'h0, busy}, 8'h00);
    diff_mode <= 1'b0;
    neg_choice <= 4'h1;
    // abort mid-conversion leaves the old result
    pulse_start(4'h3);
    repeat (10) @(posedge clk);
    converter_on <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check("abort busy", {7'h0, busy}, 8'h00);
    repeat (60) @(posedge clk);
    rd(sar_adc_pkg::RESULT_ADDR, last_r);
    repeat (3) @(posedge clk);
    finish_test();
  end
endmodule
`default_nettype wire
